// File: logic/xyds_pkg.sv
// Package: constants, register map and types of the X/Y data space access block
package xyds_pkg;
	// ==========================================================
	// Address space
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int BANK_WORDS = 32;
	localparam int IDX_W = 5;
	localparam logic [15:0] WORK_REG0_ADDR = 16'h0000;
	localparam logic [15:0] X_BASE = 16'h0800;
	localparam logic [15:0] XY_BOUND = 16'h0840;
	localparam logic [15:0] Y_LIMIT = 16'h0880;
	// ==========================================================
	// APB register byte offsets
	localparam logic [7:0] OFF_WORK_REG0 = 8'h00;
	localparam logic [7:0] OFF_CTRL = 8'h10;
	localparam logic [7:0] OFF_XMOD_START = 8'h14;
	localparam logic [7:0] OFF_XMOD_END = 8'h18;
	localparam logic [7:0] OFF_YMOD_START = 8'h1c;
	localparam logic [7:0] OFF_YMOD_END = 8'h20;
	localparam logic [7:0] OFF_BREV_MOD = 8'h24;
	localparam logic [7:0] OFF_STATUS = 8'h28;
	localparam logic [7:0] OFF_BOUND = 8'h2c;
	// ==========================================================
	// Field positions
	localparam int CTRL_XMOD_EN = 0;
	localparam int CTRL_YMOD_EN = 1;
	localparam int CTRL_BREV_EN = 2;
	localparam int STAT_UNIMPL = 0;
	localparam int STAT_LAST_Y = 1;
	// ==========================================================
	// Reset values
	localparam logic [15:0] WORK_REG0_RST = 16'h0000;
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam logic [15:0] MOD_RST = 16'h0000;
	// ==========================================================
	// Dual operand operations
	typedef enum logic [7:0] {
		OP_ACC_CLEAR = 8'h01,
		OP_DISTANCE_SQUARE = 8'h02,
		OP_DISTANCE_ACCUMULATE = 8'h04,
		OP_MULTIPLY_ACCUMULATE = 8'h08,
		OP_ACC_PREFETCH_MOVE = 8'h10,
		OP_MULTIPLY = 8'h20,
		OP_MULTIPLY_NEGATE = 8'h40,
		OP_MULTIPLY_SUBTRACT = 8'h80
	} xyds_op_t;
endpackage : xyds_pkg

// File: logic/xyds_top.sv
// Top: X/Y data space banks, address generators, read/write routing and APB registers
//
// Notes on behaviour
// - Separate X and Y generators and paths
// - All instructions and modes reach X
// - X reads and writes use separate buses
// - Unified-range reads return on X bus
// - Dual operand X prefetch uses X bus
// - Dual operand ops read Y concurrently
// - Modulo wrap available in X and Y
// - Bit-reverse only for X writes
// - Writes decode against combined X+Y range
// - Boundary fixed, not software movable
// - Effective addresses are 16-bit byte addresses
// - Unimplemented addresses read as zero
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module xyds_top (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RST,
	// APB slave
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	// Single operand X read (unified range)
	input wire logic I_X_RD_EN,
	input wire logic [xyds_pkg::ADDR_W-1:0] I_X_RD_PTR,
	input wire logic signed [2:0] I_X_RD_STEP,
	input wire logic I_X_RD_BYTE,
	// Dual operand read
	input wire logic I_DUAL_EN,
	input wire xyds_pkg::xyds_op_t I_DUAL_OP,
	input wire logic [xyds_pkg::ADDR_W-1:0] I_DUAL_X_PTR,
	input wire logic [xyds_pkg::ADDR_W-1:0] I_DUAL_Y_PTR,
	input wire logic signed [2:0] I_DUAL_STEP,
	// Write (unified range)
	input wire logic I_WR_EN,
	input wire logic [xyds_pkg::ADDR_W-1:0] I_WR_PTR,
	input wire logic [xyds_pkg::DATA_W-1:0] I_WR_DATA,
	input wire logic I_WR_BYTE,
	input wire logic signed [2:0] I_WR_STEP,
	input wire logic I_WR_BREV,
	// Read results and updated pointers
	output logic [xyds_pkg::DATA_W-1:0] O_X_RD_DATA,
	output logic O_X_RD_VALID,
	output logic [xyds_pkg::DATA_W-1:0] O_Y_RD_DATA,
	output logic O_Y_RD_VALID,
	output logic [xyds_pkg::ADDR_W-1:0] O_X_PTR_NEXT,
	output logic [xyds_pkg::ADDR_W-1:0] O_Y_PTR_NEXT,
	output logic [xyds_pkg::ADDR_W-1:0] O_WR_PTR_NEXT,
	output logic [xyds_pkg::DATA_W-1:0] O_WORK_REG0
);
	import xyds_pkg::*;

	// ==========================================================
	// Helpers
	function automatic logic in_x(input logic [15:0] ea);
		in_x = (ea >= X_BASE) && (ea < XY_BOUND);
	endfunction : in_x

	function automatic logic in_y(input logic [15:0] ea);
		in_y = (ea >= XY_BOUND) && (ea < Y_LIMIT);
	endfunction : in_y

	function automatic logic [IDX_W-1:0] x_idx(input logic [15:0] ea);
		logic [15:0] d;
		d = ea - X_BASE;
		x_idx = d[IDX_W:1];
	endfunction : x_idx

	function automatic logic [IDX_W-1:0] y_idx(input logic [15:0] ea);
		logic [15:0] d;
		d = ea - XY_BOUND;
		y_idx = d[IDX_W:1];
	endfunction : y_idx

	// Byte reads land in the low lane, upper lane zero
	function automatic logic [15:0] lane(input logic [15:0] w, input logic bsel,
			input logic a0);
		if (!bsel) begin
			lane = w;
		end else if (a0) begin
			lane = {8'h00, w[15:8]};
		end else begin
			lane = {8'h00, w[7:0]};
		end
	endfunction : lane

	// Post-modify with optional circular wrap on word pointers
	function automatic logic [15:0] addr_gen_next(input logic [15:0] p,
			input logic signed [2:0] s,
			input logic men, input logic [15:0] ms, input logic [15:0] me);
		logic [15:0] n;
		n = p + {{13{s[2]}}, s};
		if (men && !s[2] && (s != 3'sd0) && (p[15:1] == me[15:1])) begin
			n = ms;
		end else if (men && s[2] && (p[15:1] == ms[15:1])) begin
			n = me;
		end
		addr_gen_next = n;
	endfunction : addr_gen_next

	function automatic logic [14:0] rev15(input logic [14:0] v);
		logic [14:0] r;
		r = 15'h0000;
		for (int i = 0; i < 15; i++) begin
			r[i] = v[14 - i];
		end
		rev15 = r;
	endfunction : rev15

	// Reverse-carry add over the word index
	function automatic logic [15:0] brev_next(input logic [15:0] p, input logic [15:0] m);
		logic [14:0] r;
		r = rev15(rev15(p[15:1]) + rev15(m[15:1]));
		brev_next = {r, 1'b0};
	endfunction : brev_next

	function automatic logic is_dual(input xyds_op_t op);
		case (op)
			OP_ACC_CLEAR, OP_DISTANCE_SQUARE, OP_DISTANCE_ACCUMULATE,
			OP_MULTIPLY_ACCUMULATE, OP_ACC_PREFETCH_MOVE, OP_MULTIPLY,
			OP_MULTIPLY_NEGATE, OP_MULTIPLY_SUBTRACT: is_dual = 1'b1;
			default: is_dual = 1'b0;
		endcase
	endfunction : is_dual

	// ==========================================================
	// State
	logic [15:0] x_mem [0:BANK_WORDS-1];
	logic [15:0] y_mem [0:BANK_WORDS-1];
	logic [15:0] work_reg0_reg;
	logic [2:0] ctrl_reg;
	logic [15:0] xms_reg, xme_reg, yms_reg, yme_reg, brev_reg;
	logic unimpl_reg;
	logic last_y_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [15:0] x_data_reg, y_data_reg;
	logic x_valid_reg, y_valid_reg;
	logic [15:0] x_ptr_reg, y_ptr_reg, wr_ptr_reg;

	logic dual_go;
	logic apb_acc;
	logic apb_wr;
	logic [15:0] x_ea;
	logic [15:0] x_word;
	logic [15:0] y_word;
	logic x_unimpl;
	logic y_unimpl;
	logic [15:0] wr_word_addr;

	assign dual_go = I_DUAL_EN && is_dual(I_DUAL_OP);
	assign apb_acc = I_PSEL && I_PENABLE && !pready_reg;
	assign apb_wr = apb_acc && I_PWRITE;
	// Dual operand prefetch takes the X read bus over single reads
	assign x_ea = dual_go ? I_DUAL_X_PTR : I_X_RD_PTR;
	assign wr_word_addr = {I_WR_PTR[15:1], 1'b0};

	// ==========================================================
	// Read routing
	always_comb begin
		x_word = 16'h0000;
		x_unimpl = 1'b0;
		if (dual_go) begin
			if (in_x(x_ea)) begin
				x_word = x_mem[x_idx(x_ea)];
			end else begin
				x_unimpl = 1'b1;
			end
		end else if ({x_ea[15:1], 1'b0} == WORK_REG0_ADDR) begin
			x_word = work_reg0_reg;
		end else if (in_x(x_ea)) begin
			x_word = x_mem[x_idx(x_ea)];
		end else if (in_y(x_ea)) begin
			x_word = y_mem[y_idx(x_ea)];
		end else begin
			x_unimpl = 1'b1;
		end
	end

	always_comb begin
		y_word = 16'h0000;
		y_unimpl = 1'b0;
		if (in_y(I_DUAL_Y_PTR)) begin
			y_word = y_mem[y_idx(I_DUAL_Y_PTR)];
		end else begin
			y_unimpl = 1'b1;
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			x_data_reg <= 16'h0000;
			x_valid_reg <= 1'b0;
			x_ptr_reg <= 16'h0000;
		end else begin
			x_valid_reg <= dual_go || I_X_RD_EN;
			if (dual_go) begin
				x_data_reg <= x_word;
				x_ptr_reg <= addr_gen_next(x_ea, I_DUAL_STEP, ctrl_reg[CTRL_XMOD_EN],
					xms_reg, xme_reg);
			end else if (I_X_RD_EN) begin
				x_data_reg <= lane(x_word, I_X_RD_BYTE, x_ea[0]);
				x_ptr_reg <= addr_gen_next(x_ea, I_X_RD_STEP, ctrl_reg[CTRL_XMOD_EN],
					xms_reg, xme_reg);
			end
		end
	end

	// Y pointer never sees bit-reverse: reads only
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			y_data_reg <= 16'h0000;
			y_valid_reg <= 1'b0;
			y_ptr_reg <= 16'h0000;
		end else begin
			y_valid_reg <= dual_go;
			if (dual_go) begin
				y_data_reg <= y_word;
				y_ptr_reg <= addr_gen_next(I_DUAL_Y_PTR, I_DUAL_STEP, ctrl_reg[CTRL_YMOD_EN],
					yms_reg, yme_reg);
			end
		end
	end

	// ==========================================================
	// Write path: decoded against the combined range
	always_ff @(posedge I_CLK) begin
		if (I_WR_EN && in_x(I_WR_PTR)) begin
			if (!I_WR_BYTE || !I_WR_PTR[0]) begin
				x_mem[x_idx(I_WR_PTR)][7:0] <= I_WR_DATA[7:0];
			end
			if (!I_WR_BYTE || I_WR_PTR[0]) begin
				x_mem[x_idx(I_WR_PTR)][15:8] <= I_WR_BYTE ? I_WR_DATA[7:0] : I_WR_DATA[15:8];
			end
		end
		if (I_WR_EN && in_y(I_WR_PTR)) begin
			if (!I_WR_BYTE || !I_WR_PTR[0]) begin
				y_mem[y_idx(I_WR_PTR)][7:0] <= I_WR_DATA[7:0];
			end
			if (!I_WR_BYTE || I_WR_PTR[0]) begin
				y_mem[y_idx(I_WR_PTR)][15:8] <= I_WR_BYTE ? I_WR_DATA[7:0] : I_WR_DATA[15:8];
			end
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			wr_ptr_reg <= 16'h0000;
			last_y_reg <= 1'b0;
		end else if (I_WR_EN) begin
			last_y_reg <= in_y(I_WR_PTR);
			if (I_WR_BREV && ctrl_reg[CTRL_BREV_EN] && in_x(I_WR_PTR)) begin
				wr_ptr_reg <= brev_next(I_WR_PTR, brev_reg);
			end else begin
				wr_ptr_reg <= addr_gen_next(I_WR_PTR, I_WR_STEP, ctrl_reg[CTRL_XMOD_EN],
					xms_reg, xme_reg);
			end
		end
	end

	// Core write to the first working register wins over a same-cycle APB write
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			work_reg0_reg <= WORK_REG0_RST;
		end else if (I_WR_EN && (wr_word_addr == WORK_REG0_ADDR)) begin
			if (!I_WR_BYTE || !I_WR_PTR[0]) begin
				work_reg0_reg[7:0] <= I_WR_DATA[7:0];
			end
			if (!I_WR_BYTE || I_WR_PTR[0]) begin
				work_reg0_reg[15:8] <= I_WR_BYTE ? I_WR_DATA[7:0] : I_WR_DATA[15:8];
			end
		end else if (apb_wr && (I_PADDR == OFF_WORK_REG0)) begin
			work_reg0_reg <= I_PWDATA[15:0];
		end
	end

	// ==========================================================
	// APB registers
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			ctrl_reg <= CTRL_RST;
			xms_reg <= MOD_RST;
			xme_reg <= MOD_RST;
			yms_reg <= MOD_RST;
			yme_reg <= MOD_RST;
			brev_reg <= MOD_RST;
		end else if (apb_wr) begin
			case (I_PADDR)
				OFF_CTRL: ctrl_reg <= I_PWDATA[2:0];
				OFF_XMOD_START: xms_reg <= I_PWDATA[15:0];
				OFF_XMOD_END: xme_reg <= I_PWDATA[15:0];
				OFF_YMOD_START: yms_reg <= I_PWDATA[15:0];
				OFF_YMOD_END: yme_reg <= I_PWDATA[15:0];
				OFF_BREV_MOD: brev_reg <= I_PWDATA[15:0];
				default: ctrl_reg <= ctrl_reg;
			endcase
		end
	end

	// Sticky zero-read flag; a new event beats a write-one-to-clear
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			unimpl_reg <= 1'b0;
		end else if ((dual_go && (x_unimpl || y_unimpl)) || (I_X_RD_EN && x_unimpl)) begin
			unimpl_reg <= 1'b1;
		end else if (apb_wr && (I_PADDR == OFF_STATUS) && I_PWDATA[STAT_UNIMPL]) begin
			unimpl_reg <= 1'b0;
		end
	end

	// One wait state; boundary register is read-only
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			pready_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= apb_acc;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
			if (apb_acc) begin
				case (I_PADDR)
					OFF_WORK_REG0: prdata_reg <= {16'h0000, work_reg0_reg};
					OFF_CTRL: prdata_reg <= {29'h00000000, ctrl_reg};
					OFF_XMOD_START: prdata_reg <= {16'h0000, xms_reg};
					OFF_XMOD_END: prdata_reg <= {16'h0000, xme_reg};
					OFF_YMOD_START: prdata_reg <= {16'h0000, yms_reg};
					OFF_YMOD_END: prdata_reg <= {16'h0000, yme_reg};
					OFF_BREV_MOD: prdata_reg <= {16'h0000, brev_reg};
					OFF_STATUS: prdata_reg <= {30'h00000000, last_y_reg, unimpl_reg};
					OFF_BOUND: prdata_reg <= {16'h0000, XY_BOUND};
					default: pslverr_reg <= 1'b1;
				endcase
			end
		end
	end

	assign O_PRDATA = prdata_reg;
	assign O_PREADY = pready_reg;
	assign O_PSLVERR = pslverr_reg;
	assign O_X_RD_DATA = x_data_reg;
	assign O_X_RD_VALID = x_valid_reg;
	assign O_Y_RD_DATA = y_data_reg;
	assign O_Y_RD_VALID = y_valid_reg;
	assign O_X_PTR_NEXT = x_ptr_reg;
	assign O_Y_PTR_NEXT = y_ptr_reg;
	assign O_WR_PTR_NEXT = wr_ptr_reg;
	assign O_WORK_REG0 = work_reg0_reg;

	// ==========================================================
	// Assertions
	a_dual_both_paths: assert property (@(posedge I_CLK) disable iff (I_RST)
		dual_go |=> (O_X_RD_VALID && O_Y_RD_VALID))
		else $error("dual read did not use both paths");
	a_wreg_core_write: assert property (@(posedge I_CLK) disable iff (I_RST)
		(I_WR_EN && !I_WR_BYTE && (I_WR_PTR == WORK_REG0_ADDR))
		|=> (O_WORK_REG0 == $past(I_WR_DATA)))
		else $error("working register write lost");
	a_rd_wr_separate: assert property (@(posedge I_CLK) disable iff (I_RST)
		(I_WR_EN && I_X_RD_EN && !dual_go) |=> O_X_RD_VALID)
		else $error("read blocked by write");
	a_unified_outside_zero: assert property (@(posedge I_CLK) disable iff (I_RST)
		(I_X_RD_EN && !dual_go && (I_X_RD_PTR >= Y_LIMIT)) |=> (O_X_RD_DATA == 16'h0000))
		else $error("unimplemented read not zero");
	a_y_only_dual: assert property (@(posedge I_CLK) disable iff (I_RST)
		O_Y_RD_VALID |-> $past(I_DUAL_EN && is_dual(I_DUAL_OP)))
		else $error("Y read without dual operand op");
	a_xmod_wrap: assert property (@(posedge I_CLK) disable iff (I_RST)
		(dual_go && ctrl_reg[CTRL_XMOD_EN] && (I_DUAL_STEP == 3'sd2)
			&& (I_DUAL_X_PTR[15:1] == xme_reg[15:1]))
		|=> (O_X_PTR_NEXT == $past(xms_reg)))
		else $error("X modulo wrap missing");
	a_y_no_brev: assert property (@(posedge I_CLK) disable iff (I_RST)
		(dual_go && !ctrl_reg[CTRL_YMOD_EN])
		|=> (O_Y_PTR_NEXT == $past(I_DUAL_Y_PTR) + {{13{$past(I_DUAL_STEP[2])}},
			$past(I_DUAL_STEP)}))
		else $error("Y pointer not linear");
	a_wr_y_decode: assert property (@(posedge I_CLK) disable iff (I_RST)
		(I_WR_EN && (I_WR_PTR >= XY_BOUND) && (I_WR_PTR < Y_LIMIT)) |=> last_y_reg)
		else $error("Y write not decoded");
	a_bound_read: assert property (@(posedge I_CLK) disable iff (I_RST)
		(apb_acc && !I_PWRITE && (I_PADDR == OFF_BOUND))
		|=> (O_PREADY && (O_PRDATA[15:0] == XY_BOUND)))
		else $error("boundary read wrong");
	a_apb_one_wait: assert property (@(posedge I_CLK) disable iff (I_RST)
		(I_PSEL && I_PENABLE && !O_PREADY) |=> O_PREADY)
		else $error("APB answer late");
endmodule : xyds_top

// File: verif/xyds_core_model.sv
// Core pipeline model: issues single reads, dual operand reads and writes
`timescale 1ns/1ps
module xyds_core_model (
	// Clock
	input wire logic i_clk,
	// Single read request
	output logic o_x_rd_en,
	output logic [15:0] o_x_rd_ptr,
	output logic signed [2:0] o_x_rd_step,
	output logic o_x_rd_byte,
	// Dual operand request
	output logic o_dual_en,
	output xyds_pkg::xyds_op_t o_dual_op,
	output logic [15:0] o_dual_x_ptr,
	output logic [15:0] o_dual_y_ptr,
	output logic signed [2:0] o_dual_step,
	// Write request
	output logic o_wr_en,
	output logic [15:0] o_wr_ptr,
	output logic [15:0] o_wr_data,
	output logic o_wr_byte,
	output logic signed [2:0] o_wr_step,
	output logic o_wr_brev
);
	import xyds_pkg::*;
	initial begin
		{o_x_rd_en, o_x_rd_ptr, o_x_rd_step, o_x_rd_byte} = '0;
		{o_dual_en, o_dual_x_ptr, o_dual_y_ptr, o_dual_step} = '0;
		o_dual_op = OP_MULTIPLY;
		{o_wr_en, o_wr_ptr, o_wr_data, o_wr_byte, o_wr_step, o_wr_brev} = '0;
	end
	// ==========================================================
	// Requests last one cycle; released enable, pointer and data lines show the inverse so stale values never match
	task automatic rd(input logic [15:0] p, input logic [2:0] s, input logic b);
		@(posedge i_clk);
		o_x_rd_en <= 1'b1;
		o_x_rd_ptr <= p;
		o_x_rd_step <= s;
		o_x_rd_byte <= b;
		@(posedge i_clk);
		o_x_rd_en <= 1'b0;
		o_x_rd_ptr <= ~p;
		#1;
	endtask : rd
	task automatic dual(input xyds_op_t op, input logic [15:0] xp, input logic [15:0] yp,
		input logic [2:0] s);
		@(posedge i_clk);
		o_dual_en <= 1'b1;
		o_dual_op <= op;
		o_dual_x_ptr <= xp;
		o_dual_y_ptr <= yp;
		o_dual_step <= s;
		@(posedge i_clk);
		o_dual_en <= 1'b0;
		o_dual_x_ptr <= ~xp;
		o_dual_y_ptr <= ~yp;
		#1;
	endtask : dual
	task automatic wr(input logic [15:0] p, input logic [15:0] d, input logic [2:0] s,
		input logic br);
		@(posedge i_clk);
		o_wr_en <= 1'b1;
		o_wr_ptr <= p;
		o_wr_data <= d;
		o_wr_step <= s;
		o_wr_brev <= br;
		@(posedge i_clk);
		o_wr_en <= 1'b0;
		o_wr_ptr <= ~p;
		o_wr_data <= ~d;
		#1;
	endtask : wr
endmodule : xyds_core_model

// File: verif/xyds_top_bench.sv
// Bench for the X/Y data space access block
`timescale 1ns/1ps
module xyds_top_bench;
	import xyds_pkg::*;
	logic clk, rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic x_en, x_byte, d_en, w_en, w_byte, w_brev, x_val, y_val;
	logic signed [2:0] x_step, d_step, w_step;
	logic [15:0] x_ptr, dx_ptr, dy_ptr, w_ptr, w_data, x_data, y_data, x_nx, y_nx, w_nx, work0;
	xyds_op_t d_op;
	int fails = 0;
	int num_checks = 0;
	xyds_core_model i_core (.i_clk(clk), .o_x_rd_en(x_en), .o_x_rd_ptr(x_ptr),
		.o_x_rd_step(x_step), .o_x_rd_byte(x_byte), .o_dual_en(d_en), .o_dual_op(d_op),
		.o_dual_x_ptr(dx_ptr), .o_dual_y_ptr(dy_ptr), .o_dual_step(d_step), .o_wr_en(w_en),
		.o_wr_ptr(w_ptr), .o_wr_data(w_data), .o_wr_byte(w_byte), .o_wr_step(w_step),
		.o_wr_brev(w_brev));
	xyds_top i_dut (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_X_RD_EN(x_en), .I_X_RD_PTR(x_ptr),
		.I_X_RD_STEP(x_step), .I_X_RD_BYTE(x_byte), .I_DUAL_EN(d_en), .I_DUAL_OP(d_op),
		.I_DUAL_X_PTR(dx_ptr), .I_DUAL_Y_PTR(dy_ptr), .I_DUAL_STEP(d_step), .I_WR_EN(w_en),
		.I_WR_PTR(w_ptr), .I_WR_DATA(w_data), .I_WR_BYTE(w_byte), .I_WR_STEP(w_step),
		.I_WR_BREV(w_brev), .O_X_RD_DATA(x_data), .O_X_RD_VALID(x_val), .O_Y_RD_DATA(y_data),
		.O_Y_RD_VALID(y_val), .O_X_PTR_NEXT(x_nx), .O_Y_PTR_NEXT(y_nx),
		.O_WR_PTR_NEXT(w_nx), .O_WORK_REG0(work0));
	// ==========================================================
	// Common tasks
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : conclude
	// Wide enough for the packed valid, data and pointer groups
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// The master never assumes a latency; the watchdog ends a hung wait
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wreg
	task automatic chkreg(input logic [7:0] a, input logic [31:0] exp, input logic experr);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		check(r, exp);
		check({31'h0, e}, {31'h0, experr});
	endtask : chkreg
	// ==========================================================
	// Scenarios
	task automatic t_regs();
		chkreg(OFF_WORK_REG0, 32'h0, 1'b0);
		chkreg(OFF_CTRL, 32'h0, 1'b0);
		chkreg(OFF_BOUND, 32'h0840, 1'b0);
		wreg(OFF_BOUND, 32'h0);
		chkreg(OFF_BOUND, 32'h0840, 1'b0);
		chkreg(8'hfc, 32'h0, 1'b1);
		wreg(OFF_WORK_REG0, 32'h1234);
		check(work0, 16'h1234);
		chkreg(OFF_WORK_REG0, 32'h1234, 1'b0);
	endtask : t_regs
	task automatic t_unified();
		i_core.wr(16'h0802, 16'ha1b2, 3'h2, 1'b0);
		check(w_nx, 16'h0804);
		i_core.wr(16'h0844, 16'h5c6d, 3'h2, 1'b0);
		chkreg(OFF_STATUS, 32'h2, 1'b0);
		i_core.rd(16'h0802, 3'h2, 1'b0);
		check({x_val, x_data, x_nx}, {1'b1, 16'ha1b2, 16'h0804});
		i_core.rd(16'h0844, 3'h2, 1'b0);
		check({x_val, y_val, x_data}, {1'b1, 1'b0, 16'h5c6d});
		i_core.rd(16'h0803, 3'h1, 1'b1);
		check(x_data, 16'h00a1);
	endtask : t_unified
	task automatic t_dual();
		for (int i = 0; i < 8; i++) begin
			i_core.dual(xyds_op_t'(8'h01 << i), 16'h0802, 16'h0844, 3'h2);
			check({x_val, y_val, x_data, y_data}, {2'b11, 16'ha1b2, 16'h5c6d});
			check({x_nx, y_nx}, {16'h0804, 16'h0846});
		end
		i_core.dual(xyds_op_t'(8'h03), 16'h0802, 16'h0844, 3'h2);
		check({x_val, y_val}, 2'b00);
		i_core.dual(OP_MULTIPLY, 16'h0802, 16'h0802, 3'h2);
		check({x_data, y_data}, {16'ha1b2, 16'h0000});
	endtask : t_dual
	task automatic t_range();
		i_core.rd(16'h1000, 3'h2, 1'b0);
		check({x_val, x_data}, {1'b1, 16'h0000});
		i_core.rd(16'hfffe, 3'h2, 1'b0);
		check({x_data, x_nx}, {16'h0000, 16'h0000});
		chkreg(OFF_STATUS, 32'h3, 1'b0);
		wreg(OFF_STATUS, 32'h1);
		chkreg(OFF_STATUS, 32'h2, 1'b0);
	endtask : t_range
	task automatic t_modulo();
		wreg(OFF_XMOD_START, 32'h0800);
		wreg(OFF_XMOD_END, 32'h0806);
		wreg(OFF_YMOD_START, 32'h0840);
		wreg(OFF_YMOD_END, 32'h0846);
		wreg(OFF_CTRL, 32'h3);
		i_core.rd(16'h0806, 3'h2, 1'b0);
		check(x_nx, 16'h0800);
		i_core.rd(16'h0800, 3'h6, 1'b0);
		check(x_nx, 16'h0806);
		i_core.dual(OP_MULTIPLY_ACCUMULATE, 16'h0802, 16'h0846, 3'h2);
		check({x_nx, y_nx}, {16'h0804, 16'h0840});
	endtask : t_modulo
	task automatic t_brev();
		wreg(OFF_CTRL, 32'h4);
		wreg(OFF_BREV_MOD, 32'h8);
		i_core.wr(16'h0808, 16'h0001, 3'h2, 1'b1);
		check(w_nx, 16'h0804);
		i_core.wr(16'h0848, 16'h0001, 3'h2, 1'b1);
		check(w_nx, 16'h084a);
		i_core.rd(16'h0808, 3'h2, 1'b0);
		check(x_nx, 16'h080a);
	endtask : t_brev
	// ==========================================================
	// Clock, reset, sequence and watchdog
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_unified();
		t_dual();
		t_range();
		t_modulo();
		t_brev();
		conclude();
	end
	// The sequence needs well under 1000 cycles
	initial begin
		#40000;
		fails++;
		conclude();
	end
endmodule : xyds_top_bench
